// [core/vsp_device.sv]
// Device end: serial command decoder, setup words and record/playback engine
// Operation
// - Sample on clock rise, shift out on fall
// - Host frames each transfer with select low
// - Frame is eight opcode plus sixteen data bits
// - First two bytes data, third byte opcode
// - Execute only when select returns high
// - Interrupt on end marker or overflow, clear next
// - Status shifts out while command shifts in
// - Run bit starts, cleared run bit ends operation
// - Cue runs 1600 times faster, stops at marker
// - Decode wake and both setup word loads
// - Playback at address or from current address
// - Record at address or from current address
// - Halt, or halt and enter standby
// - Every frame returns flags; halt opcode also polls
// - Setup word a waits for setup word b
// - Host waits wake delay after wake command
// - Record ends on overflow or halt with interrupt
// - Control bits act as individually defined
// - Speaker and aux drive field decode
// - Speaker path source select field
// - Line out source field, two codes unused
// - Power-off bits mean off when one
// - Setup changes appear only while powered
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vsp_device
   import vsp_pkg::*;
#(
   parameter int ROW_W = 16,
   parameter int ROW_CYCLES = ROW_CYCLES_DEF
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   vsp_link_if.dev link,
   output logic poweredOn,
   output logic playing,
   output logic recording,
   output logic cueing,
   output logic [ROW_W-1:0] rowAddr,
   output logic [DATA_W-1:0] setupAOut,
   output logic [DATA_W-1:0] setupBOut,
   output logic speakerOn,
   output logic speakerHighGain,
   output logic auxOutOn,
   output logic [1:0] outputSel,
   output logic [2:0] lineOutSel,
   output logic lineOutSelValid,
   output logic volumeOff,
   output logic lineOutOff,
   output logic auxInOff,
   output logic phoneInOff
);
   localparam int CUE_CYCLES = ROW_CYCLES / CUE_SPEEDUP;
   localparam logic [4:0] CNT_FULL = 5'(FRAME_BITS);
   localparam logic [4:0] CNT_OVER = 5'(FRAME_BITS + 1);
   localparam int TICK_W = $clog2(ROW_CYCLES + 1);
   localparam logic [ROW_W-1:0] ROW_MAX = '1;

   // Refuse sizes the engine cannot serve
   if (ROW_W < 4 || ROW_W > DATA_W) begin : g_bad_row
      $error("vsp_device: ROW_W must be 4 to 16");
   end
   if (ROW_CYCLES % CUE_SPEEDUP != 0 || ROW_CYCLES < CUE_SPEEDUP) begin : g_bad_rate
      $error("vsp_device: ROW_CYCLES must be a multiple of the cue speedup");
   end

   logic [2:0] ssSync_ff;
   logic [2:0] sclkSync_ff;
   logic [1:0] mosiSync_ff;
   logic [4:0] bitCnt_ff;
   logic [FRAME_BITS-1:0] rxShift_ff;
   logic [FRAME_BITS-1:0] txShift_ff;
   logic [FRAME_BITS-1:0] statusWord;
   logic [DATA_W-1:0] pendA_ff;
   logic [DATA_W-1:0] actA_ff;
   logic [DATA_W-1:0] actB_ff;
   logic [DATA_W-1:0] effA_ff;
   logic [DATA_W-1:0] effB_ff;
   logic powered_ff;
   vsp_mode_t mode_ff;
   logic [ROW_W-1:0] addr_ff;
   logic [TICK_W-1:0] tick_ff;
   logic eom_ff;
   logic ovf_ff;
   logic intr_ff;
   logic eomMark [2**ROW_W];
   logic [OP_W-1:0] op;
   logic [DATA_W-1:0] dat;
   logic ssFall, ssRise, sclkRise, sclkFall, frameOk;
   logic ldA, ldB, runCmd, stopCmd, haltRec;
   logic stepNow, hitMark, hitEnd, endEom, endOvf;
   logic memWe, memWd;
   logic [TICK_W-1:0] period;

   // Pins pass two flops; stage 2 only feeds the edge detectors
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ssSync_ff <= 3'h7;
         sclkSync_ff <= 3'h0;
         mosiSync_ff <= 2'h0;
      end else begin
         ssSync_ff <= {ssSync_ff[1:0], link.ssN};
         sclkSync_ff <= {sclkSync_ff[1:0], link.sclk};
         mosiSync_ff <= {mosiSync_ff[0], link.mosi};
      end
   end

   assign ssFall = ssSync_ff[2] & ~ssSync_ff[1];
   assign ssRise = ~ssSync_ff[2] & ssSync_ff[1];
   assign sclkRise = ~ssSync_ff[1] & ~sclkSync_ff[2] & sclkSync_ff[1];
   assign sclkFall = ~ssSync_ff[1] & sclkSync_ff[2] & ~sclkSync_ff[1];
   assign frameOk = ssRise & (bitCnt_ff == CNT_FULL);

   // Input shift, first bit ends up lowest; count saturates past a full frame
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bitCnt_ff <= 5'h0;
         rxShift_ff <= '0;
      end else if (ssFall) begin
         bitCnt_ff <= 5'h0;
      end else if (sclkRise) begin
         rxShift_ff <= {mosiSync_ff[1], rxShift_ff[FRAME_BITS-1:1]};
         bitCnt_ff <= (bitCnt_ff == CNT_OVER) ? CNT_OVER : bitCnt_ff + 5'h1;
      end
   end

   // Status snapshot taken at select fall, so it matches what is reported
   always_comb begin
      statusWord = '0;
      statusWord[ST_OVF] = ovf_ff;
      statusWord[ST_EOM] = eom_ff;
      statusWord[ST_ADDR_LO +: ROW_W] = addr_ff;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txShift_ff <= '0;
      end else if (ssFall) begin
         txShift_ff <= statusWord;
      end else if (sclkFall) begin
         txShift_ff <= {1'b0, txShift_ff[FRAME_BITS-1:1]};
      end
   end
   assign link.miso = txShift_ff[0];

   // Decode: data in the first two bytes, opcode in the third
   assign op = rxShift_ff[OP_LO +: OP_W];
   assign dat = rxShift_ff[DATA_W-1:0];
   assign ldA = frameOk & op[OPB_LD0];
   assign ldB = frameOk & op[OPB_LD1];
   assign runCmd = frameOk & op[OPB_RUN] & op[OPB_PWR] & ~op[OPB_LD0] & ~op[OPB_LD1];
   assign stopCmd = frameOk & (~op[OPB_RUN] | ~op[OPB_PWR]);
   assign haltRec = stopCmd & (mode_ff == MD_REC);

   // Power bit is obeyed by every complete frame
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         powered_ff <= 1'b0;
      end else if (frameOk) begin
         powered_ff <= op[OPB_PWR];
      end
   end

   // Setup word a is parked until setup word b is written
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pendA_ff <= SETUP_RST;
         actA_ff <= SETUP_RST;
         actB_ff <= SETUP_RST;
      end else begin
         if (ldA) begin
            pendA_ff <= dat;
         end
         if (ldB) begin
            actB_ff <= dat;
            actA_ff <= ldA ? dat : pendA_ff;
         end
      end
   end

   // Settings reach the analogue side only while powered
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         effA_ff <= SETUP_RST;
         effB_ff <= SETUP_RST;
      end else begin
         effA_ff <= powered_ff ? actA_ff : SETUP_RST;
         effB_ff <= powered_ff ? actB_ff : SETUP_RST;
      end
   end

   // Engine stepping; cue shares the play path at a shorter row time
   assign period = (mode_ff == MD_CUE) ? TICK_W'(CUE_CYCLES - 1) : TICK_W'(ROW_CYCLES - 1);
   assign stepNow = (mode_ff != MD_IDLE) && (tick_ff == period);
   assign hitMark = eomMark[addr_ff] && (mode_ff != MD_REC);
   assign hitEnd = addr_ff == ROW_MAX;
   assign endEom = stepNow & hitMark;
   assign endOvf = stepNow & ~hitMark & hitEnd;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_ff <= MD_IDLE;
         addr_ff <= '0;
         tick_ff <= '0;
      end else if (stopCmd) begin
         mode_ff <= MD_IDLE;
         tick_ff <= '0;
      end else if (runCmd) begin
         tick_ff <= '0;
         if (op[OPB_CUE]) begin
            mode_ff <= MD_CUE;
         end else if (op[OPB_PLAY]) begin
            mode_ff <= MD_PLAY;
         end else begin
            mode_ff <= MD_REC;
         end
         if (!op[OPB_SKIP]) begin
            addr_ff <= dat[ROW_W-1:0];
         end
      end else if (stepNow) begin
         tick_ff <= '0;
         if (!hitEnd || endEom) begin
            addr_ff <= addr_ff + 1'b1;
         end
         if (endEom || endOvf) begin
            mode_ff <= MD_IDLE;
         end
      end else if (mode_ff != MD_IDLE) begin
         tick_ff <= tick_ff + 1'b1;
      end
   end

   // Marker store: recording clears rows, a halt marks where it stopped
   always_comb begin
      memWe = 1'b0;
      memWd = 1'b0;
      if (haltRec) begin
         memWe = 1'b1;
         memWd = 1'b1;
      end else if (stepNow && mode_ff == MD_REC && !runCmd && !stopCmd) begin
         memWe = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (memWe) begin
         eomMark[addr_ff] <= memWd;
      end
   end

   // Sticky flags; a new event beats the clear from a finished frame
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         eom_ff <= 1'b0;
         ovf_ff <= 1'b0;
         intr_ff <= 1'b0;
      end else begin
         eom_ff <= endEom | (eom_ff & ~frameOk);
         ovf_ff <= endOvf | (ovf_ff & ~frameOk);
         intr_ff <= endEom | endOvf | haltRec | (intr_ff & ~frameOk);
      end
   end
   assign link.intReqN = ~intr_ff;

   // User-side view of state and decoded setup fields
   assign poweredOn = powered_ff;
   assign playing = mode_ff == MD_PLAY;
   assign recording = mode_ff == MD_REC;
   assign cueing = mode_ff == MD_CUE;
   assign rowAddr = addr_ff;
   assign setupAOut = effA_ff;
   assign setupBOut = effB_ff;
   assign speakerOn = (effA_ff[SA_DRIVE_LO +: 2] == DRV_SPK_HI) ||
      (effA_ff[SA_DRIVE_LO +: 2] == DRV_SPK_LO);
   assign speakerHighGain = effA_ff[SA_DRIVE_LO +: 2] == DRV_SPK_HI;
   assign auxOutOn = effA_ff[SA_DRIVE_LO +: 2] == DRV_AUX;
   assign outputSel = effA_ff[SA_OSEL_LO +: 2];
   assign lineOutSel = effA_ff[SA_LSRC_LO +: 3];
   assign lineOutSelValid = effA_ff[SA_LSRC_LO +: 3] <= LSRC_LAST;
   assign volumeOff = effA_ff[SA_VOL_OFF];
   assign lineOutOff = effA_ff[SA_LOUT_OFF];
   assign auxInOff = effA_ff[SA_AUX_OFF];
   assign phoneInOff = effA_ff[SA_PHONE_OFF];
endmodule : vsp_device
`default_nettype wire

// [core/vsp_pkg.sv]
// Shared constants and types for the voice store serial command port
package vsp_pkg;
   // Frame geometry: sixteen data bits first, then the eight-bit opcode
   localparam int FRAME_BITS = 24;
   localparam int DATA_W = 16;
   localparam int OP_W = 8;
   localparam int OP_LO = 16;

   // Opcode bit positions
   localparam int OPB_RUN = 7;
   localparam int OPB_PLAY = 6;
   localparam int OPB_PWR = 5;
   localparam int OPB_SKIP = 4;
   localparam int OPB_CUE = 3;
   localparam int OPB_LD1 = 2;
   localparam int OPB_LD0 = 1;

   // Whole opcodes, as software writes them
   localparam logic [7:0] OP_WAKE = 8'h60;
   localparam logic [7:0] OP_WR_A = 8'h42;
   localparam logic [7:0] OP_WR_B = 8'h44;
   localparam logic [7:0] OP_PLAY_AT = 8'he0;
   localparam logic [7:0] OP_PLAY = 8'hf0;
   localparam logic [7:0] OP_REC_AT = 8'ha0;
   localparam logic [7:0] OP_REC = 8'hb0;
   localparam logic [7:0] OP_CUE = 8'hf8;
   localparam logic [7:0] OP_HALT = 8'h70;
   localparam logic [7:0] OP_HALT_SLEEP = 8'h50;

   // Field positions inside setup_word_a
   localparam int SA_VOL_OFF = 0;
   localparam int SA_DRIVE_LO = 1;
   localparam int SA_OSEL_LO = 3;
   localparam int SA_LOUT_OFF = 5;
   localparam int SA_LSRC_LO = 6;
   localparam int SA_AUX_OFF = 10;
   localparam int SA_PHONE_OFF = 13;

   // Speaker and aux drive codes
   localparam logic [1:0] DRV_OFF = 2'h0;
   localparam logic [1:0] DRV_SPK_HI = 2'h1;
   localparam logic [1:0] DRV_SPK_LO = 2'h2;
   localparam logic [1:0] DRV_AUX = 2'h3;
   localparam logic [2:0] LSRC_LAST = 3'h5;

   // Values after reset
   localparam logic [15:0] SETUP_RST = 16'h0000;

   // Status word shifted out on the return line
   localparam int ST_OVF = 0;
   localparam int ST_EOM = 1;
   localparam int ST_ADDR_LO = 8;

   // Timing
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int CUE_SPEEDUP = 1600;
   localparam int ROW_CYCLES_DEF = 16000;
   localparam int WAKE_DELAY_US = 25000;
   localparam int WAKE_CYCLES = WAKE_DELAY_US * (SYS_CLK_HZ / 1_000_000);
   localparam int SCLK_HALF_CYCLES = 8;

   // Host register map on the AHB-Lite side
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RX = 8'h08;
   localparam int HST_BUSY = 0;
   localparam int HST_WAKE = 1;
   localparam int HST_INT = 2;

   typedef enum logic [1:0] {MD_IDLE, MD_PLAY, MD_REC, MD_CUE} vsp_mode_t;
   typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP, HS_WAKE} vsp_host_state_t;
endpackage : vsp_pkg

// [core/vsp_link_if.sv]
// Four-wire serial link plus interrupt line between host and device
`timescale 1ns/1ps
`default_nettype none
interface vsp_link_if;
   logic ssN;
   logic sclk;
   logic mosi;
   logic miso;
   logic intReqN;

   modport dev (input ssN, input sclk, input mosi, output miso, output intReqN);
   modport host (output ssN, output sclk, output mosi, input miso, input intReqN);
endinterface : vsp_link_if
`default_nettype wire

// [core/vsp_host.sv]
// Host end: AHB-Lite register slave that runs frames on the serial link
`timescale 1ns/1ps
`default_nettype none
module vsp_host
   import vsp_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYCLES,
   parameter int WAKE_CYC = WAKE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   vsp_link_if.host link
);
   localparam int CNT_W = $clog2(WAKE_CYC + HALF_CYC + 2);
   localparam logic [4:0] BITS_END = 5'(FRAME_BITS);

   // Two-flop sampling of the device reply must settle before our rise
   if (HALF_CYC < 6 || WAKE_CYC < 1) begin : g_bad_timing
      $error("vsp_host: HALF_CYC must be at least 6");
   end

   vsp_host_state_t state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [4:0] bitIdx_ff;
   logic [FRAME_BITS-1:0] txShift_ff;
   logic [FRAME_BITS-1:0] rxShift_ff;
   logic [FRAME_BITS-1:0] rxWord_ff;
   logic [1:0] misoSync_ff;
   logic [1:0] intSync_ff;
   logic ssN_ff, sclk_ff, mosi_ff;
   logic wrPend_ff;
   logic [7:0] wrAddr_ff;
   logic [31:0] hrdata_ff;
   logic addrPhase, launch, halfDone, wakeSent;

   // Device pins pass two flops
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         misoSync_ff <= 2'h0;
         intSync_ff <= 2'h3;
      end else begin
         misoSync_ff <= {misoSync_ff[0], link.miso};
         intSync_ff <= {intSync_ff[0], link.intReqN};
      end
   end

   // Zero-wait slave; read data registered in the address phase
   assign addrPhase = hsel & htrans[1] & hready;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPend_ff <= 1'b0;
         wrAddr_ff <= 8'h00;
         hrdata_ff <= 32'h0;
      end else begin
         wrPend_ff <= addrPhase & hwrite;
         wrAddr_ff <= haddr[7:0];
         if (addrPhase && !hwrite) begin
            unique case (haddr[7:0])
               REG_STATUS: hrdata_ff <= {29'h0, ~intSync_ff[1], state_ff == HS_WAKE,
                  state_ff != HS_IDLE};
               REG_RX: hrdata_ff <= {8'h00, rxWord_ff};
               REG_CMD: hrdata_ff <= {8'h00, txShift_ff};
               default: hrdata_ff <= 32'h0;
            endcase
         end
      end
   end
   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // A command write starts a frame only when the link is free
   assign launch = wrPend_ff && wrAddr_ff == REG_CMD && state_ff == HS_IDLE;
   assign halfDone = cnt_ff == CNT_W'(HALF_CYC - 1);
   assign wakeSent = txShift_ff[FRAME_BITS-1 -: OP_W] == OP_WAKE;

   // Frame sequencer: select low, 24 clocks, select high, then a gap
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= HS_IDLE;
         cnt_ff <= '0;
         bitIdx_ff <= 5'h0;
         txShift_ff <= '0;
         rxShift_ff <= '0;
         rxWord_ff <= '0;
         ssN_ff <= 1'b1;
         sclk_ff <= 1'b0;
         mosi_ff <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
         unique case (state_ff)
            HS_IDLE: begin
               cnt_ff <= '0;
               if (launch) begin
                  txShift_ff <= hwdata[FRAME_BITS-1:0];
                  mosi_ff <= hwdata[0];
                  ssN_ff <= 1'b0;
                  bitIdx_ff <= 5'h0;
                  state_ff <= HS_LOW;
               end
            end
            HS_LOW: if (halfDone) begin
               cnt_ff <= '0;
               if (bitIdx_ff == BITS_END) begin
                  ssN_ff <= 1'b1;
                  rxWord_ff <= rxShift_ff;
                  state_ff <= HS_GAP;
               end else begin
                  sclk_ff <= 1'b1;
                  rxShift_ff <= {misoSync_ff[1], rxShift_ff[FRAME_BITS-1:1]};
                  state_ff <= HS_HIGH;
               end
            end
            HS_HIGH: if (halfDone) begin
               cnt_ff <= '0;
               sclk_ff <= 1'b0;
               mosi_ff <= txShift_ff[(bitIdx_ff + 5'h1) % 5'(FRAME_BITS)];
               bitIdx_ff <= bitIdx_ff + 5'h1;
               state_ff <= HS_LOW;
            end
            HS_GAP: if (halfDone) begin
               cnt_ff <= '0;
               state_ff <= wakeSent ? HS_WAKE : HS_IDLE;
            end
            HS_WAKE: if (cnt_ff == CNT_W'(WAKE_CYC - 1)) begin
               state_ff <= HS_IDLE;
            end
         endcase
      end
   end

   assign link.ssN = ssN_ff;
   assign link.sclk = sclk_ff;
   assign link.mosi = mosi_ff;
endmodule : vsp_host
`default_nettype wire

// [dv/vsp_link_monitor.sv]
// Checker for the serial wires joining host and device ends
`timescale 1ns/1ps
`default_nettype none
module vsp_link_monitor
   import vsp_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYCLES
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ssN,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic intReqN
);
   logic sclkQ_ff;
   logic ssQ_ff;
   logic [7:0] highCnt_ff;
   logic [5:0] riseCnt_ff;
   logic [7:0] sinceSs_ff;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // Last sampled level of both link strobes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclkQ_ff <= 1'b0;
         ssQ_ff <= 1'b1;
      end else begin
         sclkQ_ff <= sclk;
         ssQ_ff <= ssN;
      end
   end

   // Length of the current high phase of the serial clock
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) highCnt_ff <= 8'h0;
      else if (sclk) highCnt_ff <= highCnt_ff + 8'h1;
      else highCnt_ff <= 8'h0;
   end

   // Rising clock edges seen inside one frame
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) riseCnt_ff <= 6'h0;
      else if (ssN) riseCnt_ff <= 6'h0;
      else if (sclk && !sclkQ_ff) riseCnt_ff <= riseCnt_ff + 6'h1;
   end

   // Cycles since the frame closed, saturating so old frames never wrap
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) sinceSs_ff <= 8'hff;
      else if (ssN && !ssQ_ff) sinceSs_ff <= 8'h0;
      else if (sinceSs_ff != 8'hff) sinceSs_ff <= sinceSs_ff + 8'h1;
   end

   AST_SCLK_IDLE: assert property (ssN |-> !sclk)
      else $error("serial clock active while deselected");
   AST_MOSI_HOLD: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("host data moved while clock high");
   AST_MISO_HOLD: assert property (sclk && $past(sclk) |-> $stable(miso))
      else $error("device data moved while clock high");
   AST_SCLK_HIGH: assert property ($fell(sclk) |-> highCnt_ff == 8'(HALF_CYC))
      else $error("serial clock high phase of wrong length");
   AST_FRAME_LEN: assert property ($rose(ssN) |-> riseCnt_ff == 6'(FRAME_BITS))
      else $error("frame closed with wrong bit count");
   AST_SS_GAP: assert property ($rose(ssN) |-> ssN [*8])
      else $error("select low again too soon");
   AST_INT_CLEAR: assert property ($rose(ssN) && !intReqN |-> ##[1:12] intReqN)
      else $error("interrupt not cleared after frame");
   AST_INT_SOURCE: assert property ($rose(intReqN) |-> sinceSs_ff <= 8'h0c)
      else $error("interrupt cleared without a frame");

   // Main traffic seen at least once
   cover property ($fell(intReqN));
   cover property ($rose(ssN) && !intReqN);
   cover property (sclk && !ssN ##1 !sclk);
endmodule : vsp_link_monitor
`default_nettype wire

// [dv/testbench.sv]
// Bench joining host and device ends, plus a raw link for bad frames
`timescale 1ns/1ps
`default_nettype none
module testbench
   import vsp_pkg::*;
;
   logic sys_clk;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, pwr, play, rec, cue, spk, spkHi, aux, lsValid, pwr2;
   logic vOff, lOff, aOff, pOff;
   logic [31:0] hrdata, r;
   logic [3:0] row;
   logic [15:0] setA, setB, a;
   logic [15:0] prevA = 16'h1234;
   logic [1:0] oSel;
   logic [2:0] lSel;
   int badCount = 0;
   int samplesChecked = 0;

   vsp_link_if link();
   vsp_link_if link2();
   vsp_host #(.WAKE_CYC(50)) i_vsp_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .link(link.host));
   vsp_device #(.ROW_W(4), .ROW_CYCLES(1600)) i_vsp_device (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .link(link.dev), .poweredOn(pwr), .playing(play), .recording(rec),
      .cueing(cue), .rowAddr(row), .setupAOut(setA), .setupBOut(setB), .speakerOn(spk),
      .speakerHighGain(spkHi), .auxOutOn(aux), .outputSel(oSel), .lineOutSel(lSel),
      .lineOutSelValid(lsValid), .volumeOff(vOff), .lineOutOff(lOff), .auxInOff(aOff),
      .phoneInOff(pOff));
   vsp_device #(.ROW_W(4), .ROW_CYCLES(1600)) i_vsp_device_2 (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .link(link2.dev), .poweredOn(pwr2), .playing(), .recording(),
      .cueing(), .rowAddr(), .setupAOut(), .setupBOut(), .speakerOn(), .speakerHighGain(),
      .auxOutOn(), .outputSel(), .lineOutSel(), .lineOutSelValid(), .volumeOff(),
      .lineOutOff(), .auxInOff(), .phoneInOff());
   vsp_link_monitor i_vsp_link_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .ssN(link.ssN), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
      .intReqN(link.intReqN));

   // 20 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task stopTest;
      if (badCount == 0 && samplesChecked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stopTest

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // One single AHB-Lite word; read data lands in r
   task xfer(input logic wr, input logic [7:0] adr, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, adr};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer

   // Busy and wake-wait both hold off the next command
   task waitIdle;
      for (int i = 0; i < 20000; i++) begin
         xfer(1'b0, REG_STATUS, 32'h0);
         if (r[1:0] == 2'h0) break;
      end
   endtask : waitIdle

   task send(input logic [7:0] op, input logic [15:0] d);
      waitIdle();
      xfer(1'b1, REG_CMD, {8'h0, op, d});
      repeat (2) @(posedge sys_clk);
      waitIdle();
   endtask : send

   task waitInt;
      for (int i = 0; i < 20000; i++) begin
         xfer(1'b0, REG_STATUS, 32'h0);
         if (r[2] === 1'b1) break;
      end
      chk(32'(link.intReqN), 32'h0);
   endtask : waitInt

   // Wake command of n bits on the second link; mosi toggles once released
   task rawFrame(input int n);
      logic [31:0] w;
      w = {8'h0, OP_WAKE, 16'h0};
      link2.ssN <= 1'b0;
      for (int i = 0; i < n; i++) begin
         link2.mosi <= w[i];
         repeat (8) @(posedge sys_clk);
         link2.sclk <= 1'b1;
         repeat (8) @(posedge sys_clk);
         link2.sclk <= 1'b0;
      end
      repeat (8) @(posedge sys_clk);
      link2.ssN <= 1'b1;
      link2.mosi <= ~w[n-1];
      repeat (16) @(posedge sys_clk);
   endtask : rawFrame

   // Main sequence
   initial begin
      link2.ssN = 1'b1;
      link2.sclk = 1'b0;
      link2.mosi = 1'b0;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      chk(32'({pwr, play, rec, cue, link.intReqN}), 32'h1);
      xfer(1'b1, 8'h0c, 32'hffffffff);
      xfer(1'b0, 8'h0c, 32'h0);
      chk(r, 32'h0);
      chk(32'(hresp), 32'h0);
      // Setup loads while asleep stay hidden until wake
      send(OP_WR_A, 16'h1234);
      send(OP_WR_B, 16'habcd);
      chk(32'({pwr, setA}), 32'h0);
      send(OP_WAKE, 16'h0);
      chk({setA, setB}, 32'h1234abcd);
      chk(32'(pwr), 32'h1);
      xfer(1'b0, REG_CMD, 32'h0);
      chk(r, {8'h0, OP_WAKE, 16'h0});
      // Every drive code; power bit set keeps power on
      for (int i = 0; i < 4; i++) begin
         a = 16'(i << 1 | i << 3 | (2 * i + 1) << 6) | (i[0] ? 16'h2421 : 16'h0);
         send(OP_WR_A | 8'h20, a);
         chk(32'(setA), 32'(prevA));
         send(OP_WR_B | 8'h20, ~a);
         chk({setA, setB}, {a, ~a});
         chk(32'({spk, spk & spkHi, aux, oSel, lSel, lsValid, vOff, lOff, aOff, pOff}),
            32'({i == 1 || i == 2, i == 1, i == 3, 2'(i), 3'(2 * i + 1), i < 3, {4{i[0]}}}));
         prevA = a;
      end
      // Record from row 0 until the array end
      send(OP_REC_AT, 16'h0);
      chk(32'({rec, row}), 32'h10);
      waitInt();
      chk(32'(rec), 32'h0);
      send(OP_HALT, 16'h0);
      xfer(1'b0, REG_RX, 32'h0);
      chk(32'({link.intReqN, r[1:0]}), 32'h5);
      // Halted recordings leave end markers at rows 6 and 3
      send(OP_REC_AT, 16'h6);
      send(OP_HALT, 16'h0);
      chk(32'({rec, link.intReqN}), 32'h0);
      send(OP_REC_AT, 16'h3);
      send(OP_HALT, 16'h0);
      send(OP_PLAY_AT, 16'h1);
      chk(32'({play, row}), 32'h11);
      waitInt();
      chk(32'({play, row}), 32'h4);
      send(OP_PLAY, 16'h9);
      waitInt();
      chk(32'(row), 32'h7);
      // Cue runs to the array end long before one play row
      send(OP_CUE, 16'h0);
      xfer(1'b0, REG_RX, 32'h0);
      chk(32'(r[23:0]), 32'h702);
      // Cue ends within a few cycles of the frame; a play row would take 1600
      repeat (8) @(posedge sys_clk);
      chk(32'({cue, link.intReqN}), 32'h0);
      // Record from the current row overflows at the array end
      send(OP_REC, 16'h2);
      chk(32'({rec, row}), 32'h1f);
      waitInt();
      chk(32'({rec, row}), 32'hf);
      send(OP_HALT_SLEEP, 16'h0);
      xfer(1'b0, REG_RX, 32'h0);
      chk(32'({pwr, setA, r[1:0]}), 32'h1);
      // Short and long frames on the raw link
      rawFrame(23);
      rawFrame(25);
      chk(32'(pwr2), 32'h0);
      rawFrame(24);
      chk(32'(pwr2), 32'h1);
      stopTest();
   end

   // Hang guard, about twice the expected run
   initial begin
      repeat (90000) @(posedge sys_clk);
      badCount++;
      stopTest();
   end
endmodule : testbench
`default_nettype wire
